// ==== verilog/brc_consts.svh ====
`ifndef BRC_CONSTS_SVH
`define BRC_CONSTS_SVH

// register offset (byte address on the wishbone bus)
`define BRC_REG_OFFSET      4'h0
// reset values
`define BRC_RESET_NORMAL    8'hfe
`define BRC_RESET_MODE34    8'hee
// field positions
`define BRC_BIT_A23         7
`define BRC_BIT_A22         6
`define BRC_BIT_A21         5
`define BRC_BIT_A20         4
`define BRC_BIT_HANDOVER    0
// reserved bits 3..1 read as one
`define BRC_RSVD_MASK       8'h0e
// writable masks per mode group
`define BRC_WMASK_MODE34    8'he1
`define BRC_WMASK_MODE5     8'hf1
`define BRC_WMASK_OTHER     8'h01
// unmapped read value
`define BRC_UNMAPPED_DATA   32'h0000_0000

`endif

// ==== verilog/brc_pkg.sv ====
package brc_pkg;

    // register contents as named fields
    typedef struct packed {
        logic       addr_bit23_pin_select;
        logic       addr_bit22_pin_select;
        logic       addr_bit21_pin_select;
        logic       addr_bit20_pin_select;
        logic [2:0] reserved;
        logic       bus_handover_enable;
    } brc_reg_t;

    // bus ownership sequence
    typedef enum logic [1:0] {
        BRC_OWNED,
        BRC_FINISH,
        BRC_RELEASED
    } brc_state_t;

    // pin select outputs for port a pins 4..7
    typedef struct packed {
        logic port_a_pin7;
        logic port_a_pin6;
        logic port_a_pin5;
        logic port_a_pin4;
    } brc_pins_t;

endpackage

// ==== verilog/brc_bus_release.sv ====
// Contract
// - reset loads fe in modes 1,2,5,6,7
// - reset loads ee in modes 3 and 4
// - reset/hw standby reload; sw standby keeps
// - bit7 zero: pin4 carries address 23
// - bit6 zero: pin5 carries address 22
// - bit5 zero: pin6 carries address 21
// - bit4 zero: pin7 carries address 20
// - bits 7..5 frozen outside modes 3,4,5
// - bit4 writable only in mode 5
// - bits 3..1 ignore writes, read one
// - bit0 zero: no release, pins general; code blocks it only in owned state, so finish still goes on to released
// - bit0 one allows release, always writable
`timescale 1ns/100ps
`default_nettype none
`include "brc_consts.svh"

module brc_bus_release (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // chip state
    input  wire logic [2:0]       mode_i,
    input  wire logic             hw_standby_i,
    input  wire logic             sw_standby_i,
    // wishbone slave
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [3:0]       wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    // internal bus cycle status
    input  wire logic             bus_cycle_busy_i,
    // bus handover pins
    input  wire logic             bus_request_n_i,
    output logic                  bus_ack_n_o,
    output logic                  bus_ack_n_oe_o,
    output logic                  bus_float_o,
    output logic                  handover_pins_gpio_o,
    // port a pin function: high means address output
    output brc_pkg::brc_pins_t    addr_pin_sel_o
);

    brc_pkg::brc_reg_t   reg_ff;
    brc_pkg::brc_state_t state_ff;
    brc_pkg::brc_state_t nxt_state;
    logic                ack_ff;
    logic [31:0]         rdat_ff;
    logic                mode34;
    logic                mode5;
    logic                req;
    logic                hit;
    logic                wr_stb;
    logic [7:0]          wmask;
    logic [7:0]          reset_val;
    logic [3:0]          pin_bit;
    logic [3:0]          pin_gate;
    logic [3:0]          pin_sel;

    assign mode34 = (mode_i == 3'h3) || (mode_i == 3'h4);
    assign mode5  = (mode_i == 3'h5);
    assign req    = wb_cyc_i && wb_stb_i && !ack_ff;
    assign hit    = (wb_adr_i == `BRC_REG_OFFSET);
    assign wr_stb = req && wb_we_i && hit && wb_sel_i[0];

    always_comb begin
        reset_val = mode34 ? `BRC_RESET_MODE34 : `BRC_RESET_NORMAL;
        if (mode34) begin
            wmask = `BRC_WMASK_MODE34;
        end else if (mode5) begin
            wmask = `BRC_WMASK_MODE5;
        end else begin
            wmask = `BRC_WMASK_OTHER;
        end
    end

    // register; sw standby has no effect so contents survive it
    always_ff @(posedge clk_i) begin
        if (rst_i || hw_standby_i) begin
            reg_ff <= brc_pkg::brc_reg_t'(reset_val);
        end else if (wr_stb) begin
            reg_ff <= brc_pkg::brc_reg_t'(((wb_dat_i[7:0] & wmask)
                      | (reg_ff & ~wmask)) | `BRC_RSVD_MASK);
        end
    end

    // single-cycle answer: ack one edge after request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_ff <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            rdat_ff <= hit ? {24'h00_0000, reg_ff | `BRC_RSVD_MASK}
                           : `BRC_UNMAPPED_DATA;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;

    // bit i of each vector belongs to port a pin 4+i
    assign pin_bit[0] = reg_ff.addr_bit23_pin_select;
    assign pin_bit[1] = reg_ff.addr_bit22_pin_select;
    assign pin_bit[2] = reg_ff.addr_bit21_pin_select;
    assign pin_bit[3] = reg_ff.addr_bit20_pin_select;
    // pin7 skips the mode gate: bit4 cannot leave its reset value there
    assign pin_gate = {1'b1, {3{mode34 || mode5}}};

    for (genvar gi = 0; gi < 4; gi++) begin : g_pin
        assign pin_sel[gi] = pin_gate[gi] && !pin_bit[gi];
    end

    assign addr_pin_sel_o = brc_pkg::brc_pins_t'(pin_sel);

    // handover sequence; own cycle is never cut short
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            brc_pkg::BRC_OWNED: begin
                if (reg_ff.bus_handover_enable && !bus_request_n_i) begin
                    nxt_state = brc_pkg::BRC_FINISH;
                end
            end
            brc_pkg::BRC_FINISH: begin
                if (bus_request_n_i) begin
                    nxt_state = brc_pkg::BRC_OWNED;
                end else if (!bus_cycle_busy_i) begin
                    nxt_state = brc_pkg::BRC_RELEASED;
                end
            end
            brc_pkg::BRC_RELEASED: begin
                if (bus_request_n_i) begin
                    nxt_state = brc_pkg::BRC_OWNED;
                end
            end
            // code 3 is unused; fall back to owning the bus
            default: begin
                nxt_state = brc_pkg::BRC_OWNED;
            end
        endcase
    end

    // a disabled handover never leaves owned state
    always_ff @(posedge clk_i) begin
        if (rst_i || hw_standby_i) begin
            state_ff <= brc_pkg::BRC_OWNED;
        end else if (!reg_ff.bus_handover_enable
                     && state_ff == brc_pkg::BRC_OWNED) begin
            state_ff <= brc_pkg::BRC_OWNED;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign bus_float_o          = (state_ff == brc_pkg::BRC_RELEASED);
    assign bus_ack_n_o          = !(state_ff == brc_pkg::BRC_RELEASED);
    assign bus_ack_n_oe_o       = reg_ff.bus_handover_enable;
    assign handover_pins_gpio_o = !reg_ff.bus_handover_enable;

    // checks
    reset_fe_a: assert property (@(posedge clk_i)
        rst_i && !mode34 |=> reg_ff == `BRC_RESET_NORMAL)
        else $error("reset value not fe");
    reset_ee_a: assert property (@(posedge clk_i)
        rst_i && mode34 |=> reg_ff == `BRC_RESET_MODE34)
        else $error("reset value not ee");
    sw_standby_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        sw_standby_i && !hw_standby_i && !wr_stb |=> $stable(reg_ff))
        else $error("register changed in sw standby");
    hw_standby_a: assert property (@(posedge clk_i)
        hw_standby_i |=> reg_ff == $past(reset_val))
        else $error("hw standby did not reload");
    pin4_sel_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        addr_pin_sel_o.port_a_pin4 == ((mode34 || mode5) && !reg_ff[7]))
        else $error("pin4 address select wrong");
    pin5_sel_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        addr_pin_sel_o.port_a_pin5 == ((mode34 || mode5) && !reg_ff[6]))
        else $error("pin5 address select wrong");
    pin6_sel_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        addr_pin_sel_o.port_a_pin6 == ((mode34 || mode5) && !reg_ff[5]))
        else $error("pin6 address select wrong");
    pin7_sel_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        addr_pin_sel_o.port_a_pin7 != reg_ff[4])
        else $error("pin7 address select wrong");
    upper_frozen_a: assert property (@(posedge clk_i)
        disable iff (rst_i || hw_standby_i)
        !mode34 && !mode5 |=> reg_ff[7:5] == $past(reg_ff[7:5]))
        else $error("bits 7..5 changed outside modes 3,4,5");
    bit4_frozen_a: assert property (@(posedge clk_i)
        disable iff (rst_i || hw_standby_i)
        !mode5 |=> reg_ff[4] == $past(reg_ff[4]))
        else $error("bit4 changed outside mode 5");
    rsvd_one_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        ack_ff && $past(!wb_we_i && hit) |-> wb_dat_o[3:1] == 3'h7)
        else $error("reserved bits not read as one");
    no_release_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        !reg_ff.bus_handover_enable && state_ff == brc_pkg::BRC_OWNED
        |=> !bus_float_o)
        else $error("bus released while disabled");
    bit0_write_a: assert property (@(posedge clk_i)
        disable iff (rst_i || hw_standby_i)
        wr_stb |=> reg_ff[0] == $past(wb_dat_i[0]))
        else $error("bit0 write lost");
    finish_first_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        state_ff == brc_pkg::BRC_FINISH && bus_cycle_busy_i
        |=> !bus_float_o)
        else $error("bus floated during own cycle");
    ack_drop_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        bus_float_o && bus_request_n_i |=> !bus_float_o && bus_ack_n_o)
        else $error("acknowledge held after request withdrawn");

    // bus, handover and register checks
    ack_pulse_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
    ack_answer_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        req |=> wb_ack_o)
        else $error("request not acknowledged");
    ack_cause_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        wb_ack_o |-> $past(req))
        else $error("acknowledge without request");
    rd_data_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        wb_ack_o && $past(!wb_we_i && hit)
        |-> wb_dat_o[7:0] == ($past(reg_ff) | `BRC_RSVD_MASK))
        else $error("read data differs from register");
    rsvd_reg_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        reg_ff.reserved == 3'h7)
        else $error("reserved bits not held at one");
    off_gpio_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        !reg_ff.bus_handover_enable |-> handover_pins_gpio_o && !bus_ack_n_oe_o)
        else $error("handover pins not general io");
    on_drive_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        reg_ff.bus_handover_enable |-> bus_ack_n_oe_o && !handover_pins_gpio_o)
        else $error("acknowledge pin not driven");
    request_wait_a: assert property (@(posedge clk_i)
        disable iff (rst_i || hw_standby_i)
        reg_ff.bus_handover_enable && state_ff == brc_pkg::BRC_OWNED
        && !bus_request_n_i |=> state_ff == brc_pkg::BRC_FINISH)
        else $error("request not taken");
    grant_a: assert property (@(posedge clk_i)
        disable iff (rst_i || hw_standby_i)
        state_ff == brc_pkg::BRC_FINISH && !bus_cycle_busy_i
        && !bus_request_n_i |=> bus_float_o && !bus_ack_n_o)
        else $error("bus not released after own cycle");
    hold_a: assert property (@(posedge clk_i)
        disable iff (rst_i || hw_standby_i)
        bus_float_o && !bus_request_n_i |=> bus_float_o)
        else $error("bus taken back while requested");
    finish_exit_a: assert property (@(posedge clk_i)
        disable iff (rst_i || hw_standby_i)
        state_ff == brc_pkg::BRC_FINISH && bus_request_n_i
        |=> state_ff == brc_pkg::BRC_OWNED)
        else $error("withdrawn request not dropped");
    legal_state_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        state_ff inside {brc_pkg::BRC_OWNED, brc_pkg::BRC_FINISH,
                         brc_pkg::BRC_RELEASED})
        else $error("handover state illegal");
    mode34_bit4_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        mode34 |-> !reg_ff.addr_bit20_pin_select)
        else $error("bit4 not zero in modes 3,4");
    other_upper_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        !mode34 && !mode5 |-> reg_ff[7:4] == 4'hf)
        else $error("bits 7..4 not one outside modes 3,4,5");
    hw_state_a: assert property (@(posedge clk_i)
        hw_standby_i |=> state_ff == brc_pkg::BRC_OWNED)
        else $error("hw standby did not reclaim bus");
    rst_state_a: assert property (@(posedge clk_i)
        rst_i |=> !bus_float_o && bus_ack_n_o && !wb_ack_o)
        else $error("outputs not idle after reset");
    bit0_hold_a: assert property (@(posedge clk_i)
        disable iff (rst_i || hw_standby_i)
        !wr_stb |=> reg_ff[0] == $past(reg_ff[0]))
        else $error("bit0 changed without write");

    release_c: cover property (@(posedge clk_i) disable iff (rst_i)
        state_ff == brc_pkg::BRC_FINISH ##1 bus_float_o);
    mode5_wr_c: cover property (@(posedge clk_i) disable iff (rst_i)
        wr_stb && mode5 && !wb_dat_i[4]);
    mode34_wr_c: cover property (@(posedge clk_i) disable iff (rst_i)
        wr_stb && mode34 && !wb_dat_i[7]);
    return_c: cover property (@(posedge clk_i) disable iff (rst_i)
        bus_float_o ##1 !bus_float_o);
    hw_reload_c: cover property (@(posedge clk_i)
        hw_standby_i ##1 !hw_standby_i);

endmodule // brc_bus_release

`default_nettype wire

// ==== verification/brc_ext_master.sv ====
`timescale 1ns/100ps
`default_nettype none
module brc_ext_master (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // bench control and pins
    input  wire logic go_i,
    input  wire logic ack_n_i,
    output logic      req_n_o
);
    logic       req_n_ff;
    logic       done_ff;
    logic [1:0] hold_ff;
    assign req_n_o = req_n_ff;
    // one request per go, held until granted, bus kept for four cycles
    always_ff @(posedge clk_i) begin
        if (rst_i || !go_i) begin
            req_n_ff <= 1'b1;
            done_ff  <= 1'b0;
            hold_ff  <= 2'h0;
        end else if (!done_ff) begin
            req_n_ff <= 1'b0;
            if (!req_n_ff && !ack_n_i) begin
                hold_ff <= hold_ff + 2'h1;
                if (hold_ff == 2'h3) begin
                    req_n_ff <= 1'b1;
                    done_ff  <= 1'b1;
                end
            end
        end
    end
endmodule // brc_ext_master
`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk_i, rst_i, hws, sws, cyc, stb, we, busy, go, req_n;
    logic [2:0] mode;
    logic [3:0] adr, sel;
    logic [31:0] dati, dato, q;
    logic ack, ack_n, ack_oe, flt, gpio, ack_pin;
    brc_pkg::brc_pins_t pins;
    logic [7:0] rv, wm, d;
    logic [3:0] pe;
    logic a;
    int err_total;
    int checks;
    // pull-up on the acknowledge pin while it is not driven
    assign ack_pin = ack_oe ? ack_n : 1'b1;
    brc_bus_release dut_u (.clk_i(clk_i), .rst_i(rst_i), .mode_i(mode),
        .hw_standby_i(hws), .sw_standby_i(sws), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dati), .wb_dat_o(dato), .wb_ack_o(ack),
        .bus_cycle_busy_i(busy), .bus_request_n_i(req_n),
        .bus_ack_n_o(ack_n), .bus_ack_n_oe_o(ack_oe), .bus_float_o(flt),
        .handover_pins_gpio_o(gpio), .addr_pin_sel_o(pins));
    brc_ext_master mst_u (.clk_i(clk_i), .rst_i(rst_i), .go_i(go),
        .ack_n_i(ack_pin), .req_n_o(req_n));
    task automatic close_out();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] ad,
                      input logic [3:0] s, input logic [7:0] dv);
        int n;
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= ad;
        sel  <= s;
        dati <= {24'h0, dv};
        n = 0;
        // sample at the falling edge, clear of the edge that moves ack
        @(negedge clk_i);
        while (ack !== 1'b1 && n < 20) begin
            @(negedge clk_i);
            n++;
        end
        chk("ack", 32'h1, {31'h0, ack});
        if (n >= 20) close_out();
        q = dato;
        @(posedge clk_i);
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [3:0] ad, input logic [7:0] e);
        wb(1'b0, ad, 4'hf, 8'h00);
        chk("reg", {24'h0, e}, q);
    endtask
    task automatic do_rst(input int n);
        rst_i <= 1'b1;
        repeat (n) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wait_flt(input logic v);
        int n;
        n = 0;
        @(negedge clk_i);
        while (flt !== v && n < 10) begin
            @(negedge clk_i);
            n++;
        end
        chk("float", {31'h0, v}, {31'h0, flt});
        if (n >= 10) close_out();
    endtask
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    initial begin
        {rst_i, hws, sws, cyc, stb, we, busy, go} = 8'h00;
        {adr, sel, dati} = 40'h0;
        mode = 3'h5;
        err_total = 0;
        checks = 0;
        do_rst(16);
        for (int m = 1; m <= 7; m++) begin
            mode <= m[2:0];
            do_rst(2);
            a  = (m >= 3 && m <= 5);
            rv = (m == 3 || m == 4) ? 8'hee : 8'hfe;
            wm = a ? ((m == 5) ? 8'hf1 : 8'he1) : 8'h01;
            rd(4'h0, rv);
            for (int k = 0; k < 2; k++) begin
                d = k ? 8'hff : 8'h00;
                wb(1'b1, 4'h0, 4'hf, d);
                rv = (rv & ~wm) | (d & wm) | 8'h0e;
                rd(4'h0, rv);
                pe = {~rv[4], ~rv[5] & a, ~rv[6] & a, ~rv[7] & a};
                chk("pins", {28'h0, pe}, 32'(pins));
            end
        end
        mode <= 3'h5;
        do_rst(2);
        wb(1'b1, 4'h0, 4'he, 8'h00);
        rd(4'h0, 8'hfe);
        wb(1'b1, 4'h0, 4'hf, 8'h00);
        sws <= 1'b1;
        repeat (4) @(posedge clk_i);
        sws <= 1'b0;
        rd(4'h0, 8'h0e);
        wb(1'b1, 4'h4, 4'hf, 8'hff);
        rd(4'h4, 8'h00);
        rd(4'h0, 8'h0e);
        hws <= 1'b1;
        @(posedge clk_i);
        hws <= 1'b0;
        @(posedge clk_i);
        rd(4'h0, 8'hfe);
        go <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk("idle pins", 32'h5, {29'h0, ack_pin, flt, gpio});
        go <= 1'b0;
        wb(1'b1, 4'h0, 4'hf, 8'h01);
        busy <= 1'b1;
        go   <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk("busy hold", 32'h4, {29'h0, ack_pin, flt, gpio});
        busy <= 1'b0;
        wait_flt(1'b1);
        chk("grant", 32'h0, {31'h0, ack_pin});
        wait_flt(1'b0);
        chk("back", 32'h1, {31'h0, ack_pin});
        @(posedge clk_i);
        go <= 1'b0;
        close_out();
    end
endmodule // testbench
`default_nettype wire
